// *** rtl/isp_serial_port.sv ***
`timescale 1ns/1ps
// Operation
// - Only programming-enable is accepted until enable has been received.
// - EEPROM byte write overwrites the location, erasing it on the way.
// - Chip erase fills flash and EEPROM with all-ones bytes.
// - Input bits are captured on serial clock rising edge.
// - Output bits are shifted on serial clock falling edge.
// - Second enable byte echoes out while third byte shifts in.
// - Page buffer loads one byte per instruction at seven-bit address.
// - Extended address byte is kept until reloaded.
// - Flash and EEPROM reads return addressed content on serial output; signature, fuse, lock and calibration reads return constants.
// - Reset pin high ends programming mode.
// - Poll byte bit zero reads one while an operation is pending.
module isp_serial_port #(
  parameter int PAGE_WAIT_CYCLES  = isp_pkg::PAGE_WAIT_CYC,
  parameter int EE_WAIT_CYCLES    = isp_pkg::EE_WAIT_CYC,
  parameter int ERASE_WAIT_CYCLES = isp_pkg::ERASE_WAIT_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Programming pins
  input  wire logic prog_reset_n,
  input  wire logic prog_sck,
  input  wire logic prog_serial_in,
  output logic      prog_serial_out,
  // Status
  output logic      prog_enabled,
  output logic      write_pending_flag
);
  import isp_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]       sck_s;
    logic             sck_d;
    logic [1:0]       sdi_s;
    logic [1:0]       rst_s;
    logic             enabled;
    logic [4:0]       bitcnt;
    logic [31:0]      rx;
    logic [7:0]       tx;
    logic             sdo;
    logic [7:0]       ext;
    logic             push_v;
    logic [31:0]      push_d;
    isp_ex_t          ex;
    logic [31:0]      cur;
    logic [CNT_W-1:0] cnt;
    logic             busy;
  } isp_st_t;

  isp_st_t          r;
  isp_st_t          n;
  logic [15:0]      fl_mem [FL_DEPTH];
  logic [7:0]       ee_mem [EE_DEPTH];
  logic [7:0]       pb_lo  [PG_DEPTH];
  logic [7:0]       pb_hi  [PG_DEPTH];
  logic             fl_we;
  logic [FL_AW-1:0] fl_wa;
  logic [15:0]      fl_wd;
  logic             ee_we;
  logic [EE_AW-1:0] ee_wa;
  logic [7:0]       ee_wd;
  logic             pbl_we;
  logic             pbh_we;
  logic [PG_AW-1:0] pb_wa;
  logic [7:0]       pb_wd;
  logic             rise;
  logic             fall;
  logic [31:0]      nrx;
  logic [7:0]       rb;
  logic [FL_AW-1:0] fa;
  logic [31:0]      d;

  isp_fifo_if #(.W(INSTR_W)) ifc ();

  isp_fifo #(.W(INSTR_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ff      (ifc)
  );

  function automatic logic [FL_AW-1:0] fl_addr(input logic [7:0] e, input logic [7:0] m,
                                               input logic [7:0] l);
    logic [23:0] w;
    w = {e, m, l};
    return w[FL_AW-1:0];
  endfunction

  assign ifc.push_valid     = r.push_v;
  assign ifc.push_data      = r.push_d;
  assign ifc.pop_ready      = (r.ex == EX_IDLE);
  assign prog_serial_out    = r.sdo;
  assign prog_enabled       = r.enabled;
  assign write_pending_flag = r.busy;

  // ----------------------------------------------------------------
  // Link side and executor
  // ----------------------------------------------------------------
  always_comb begin
    n      = r;
    fl_we  = 1'b0;
    fl_wa  = '0;
    fl_wd  = '0;
    ee_we  = 1'b0;
    ee_wa  = '0;
    ee_wd  = '0;
    pbl_we = 1'b0;
    pbh_we = 1'b0;
    pb_wa  = '0;
    pb_wd  = '0;
    d      = ifc.pop_data;
    n.sck_s = {r.sck_s[0], prog_sck};
    n.sdi_s = {r.sdi_s[0], prog_serial_in};
    n.rst_s = {r.rst_s[0], prog_reset_n};
    n.sck_d = r.sck_s[1];
    rise    = r.sck_s[1] & ~r.sck_d;
    fall    = ~r.sck_s[1] & r.sck_d;
    nrx     = {r.rx[30:0], r.sdi_s[1]};
    fa      = fl_addr(r.ext, nrx[15:8], nrx[7:0]);
    n.push_v = 1'b0;
    rb = 8'h00;
    if (r.enabled) begin
      case (nrx[23:16])
        OP_RD_LO:   rb = fl_mem[fa][7:0];
        OP_RD_HI:   rb = fl_mem[fa][15:8];
        OP_RD_EE:   rb = ee_mem[nrx[EE_AW-1:0]];
        OP_POLL:    rb = {7'h00, r.busy};
        OP_RD_SIG:  rb = SIG_VAL;
        OP_RD_FUSE: rb = FUSE_VAL;
        OP_RD_LOCK: rb = FUSE_VAL;
        OP_RD_CAL:  rb = FUSE_VAL;
        default:    rb = 8'h00;
      endcase
    end
    if (r.rst_s[1]) begin
      n.enabled = 1'b0;
      n.bitcnt  = '0;
      n.tx      = '0;
      n.sdo     = 1'b0;
    end else if (rise) begin
      n.rx     = nrx;
      n.bitcnt = r.bitcnt + 1'b1;
      if (r.bitcnt[2:0] == BIT_LAST) begin
        if (r.bitcnt[4:3] == BYTE_3) begin
          n.tx = rb;
        end else if (r.bitcnt[4:3] == BYTE_4) begin
          n.tx = 8'h00;
          if (nrx[31:16] == {OP_ENABLE, SUB_ENABLE}) begin
            n.enabled = 1'b1;
          end else if (r.enabled && nrx[31:24] != OP_POLL) begin
            n.push_v = ifc.push_ready;
            n.push_d = nrx;
          end
        end else begin
          n.tx = nrx[7:0];
        end
      end
    end else if (fall) begin
      n.sdo = r.tx[7];
      n.tx  = {r.tx[6:0], 1'b0};
    end

    case (r.ex)
      EX_IDLE: begin
        if (ifc.pop_valid) begin
          n.cur = d;
          case (d[31:24])
            OP_LD_EXT: n.ext = d[15:8];
            OP_LD_LO: begin
              pbl_we = 1'b1;
              pb_wa  = d[PG_AW+7:8];
              pb_wd  = d[7:0];
            end
            OP_LD_HI: begin
              pbh_we = 1'b1;
              pb_wa  = d[PG_AW+7:8];
              pb_wd  = d[7:0];
            end
            OP_WR_PAGE: begin
              n.ex  = EX_PAGE;
              n.cnt = '0;
            end
            OP_WR_EE: begin
              ee_we = 1'b1;
              ee_wa = d[EE_AW+7:8];
              ee_wd = d[7:0];
              n.ex  = EX_WAIT;
              n.cnt = CNT_W'(EE_WAIT_CYCLES - 1);
            end
            OP_ENABLE: begin
              if (d[23:16] == SUB_ERASE) begin
                n.ex  = EX_ERASE;
                n.cnt = '0;
              end
            end
            default: ;
          endcase
        end
      end
      EX_PAGE: begin
        fl_we = 1'b1;
        fl_wa = fl_addr(r.ext, r.cur[23:16], {r.cur[15], r.cnt[PG_AW-1:0]});
        fl_wd = {pb_hi[r.cnt[PG_AW-1:0]], pb_lo[r.cnt[PG_AW-1:0]]};
        if (r.cnt == CNT_W'(PG_DEPTH - 1)) begin
          n.ex  = EX_WAIT;
          n.cnt = CNT_W'(PAGE_WAIT_CYCLES - 1);
        end else begin
          n.cnt = r.cnt + 1'b1;
        end
      end
      EX_ERASE: begin
        fl_we = 1'b1;
        fl_wa = r.cnt[FL_AW-1:0];
        fl_wd = {ERASED, ERASED};
        ee_we = 1'b1;
        ee_wa = r.cnt[EE_AW-1:0];
        ee_wd = ERASED;
        if (r.cnt == CNT_W'(EE_DEPTH - 1)) begin
          n.ex  = EX_WAIT;
          n.cnt = CNT_W'(ERASE_WAIT_CYCLES - 1);
        end else begin
          n.cnt = r.cnt + 1'b1;
        end
      end
      EX_WAIT: begin
        if (r.cnt == '0) begin
          n.ex = EX_IDLE;
        end else begin
          n.cnt = r.cnt - 1'b1;
        end
      end
      default: n.ex = EX_IDLE;
    endcase
    n.busy = (n.ex != EX_IDLE) | ifc.pop_valid | n.push_v | r.push_v;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r     <= '0;
      r.ex  <= EX_IDLE;
      r.sck_s <= '0;
      r.rst_s <= 2'h3;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Storage arrays
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (fl_we) begin
      fl_mem[fl_wa] <= fl_wd;
    end
    if (ee_we) begin
      ee_mem[ee_wa] <= ee_wd;
    end
    if (pbl_we) begin
      pb_lo[pb_wa] <= pb_wd;
    end
    if (pbh_we) begin
      pb_hi[pb_wa] <= pb_wd;
    end
  end
endmodule // isp_serial_port

// *** rtl/isp_pkg.sv ***
package isp_pkg;

  // ----------------------------------------------------------------
  // Clock and wait times
  // ----------------------------------------------------------------
  localparam int CLK_MHZ        = 40;
  localparam int PAGE_WAIT_US   = 4500;
  localparam int EE_WAIT_US     = 9000;
  localparam int ERASE_WAIT_US  = 9000;
  localparam int PAGE_WAIT_CYC  = PAGE_WAIT_US * CLK_MHZ;
  localparam int EE_WAIT_CYC    = EE_WAIT_US * CLK_MHZ;
  localparam int ERASE_WAIT_CYC = ERASE_WAIT_US * CLK_MHZ;
  localparam int CNT_W          = 19;

  // ----------------------------------------------------------------
  // Storage geometry
  // ----------------------------------------------------------------
  localparam int FL_AW      = 10;
  localparam int FL_DEPTH   = 1 << FL_AW;
  localparam int EE_AW      = 12;
  localparam int EE_DEPTH   = 1 << EE_AW;
  localparam int PG_AW      = 7;
  localparam int PG_DEPTH   = 1 << PG_AW;
  localparam int INSTR_W    = 32;
  localparam int FIFO_DEPTH = 32;

  // ----------------------------------------------------------------
  // Instruction first bytes and values
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_ENABLE  = 8'hAC;
  localparam logic [7:0] SUB_ENABLE = 8'h53;
  localparam logic [7:0] SUB_ERASE  = 8'h80;
  localparam logic [7:0] OP_POLL    = 8'hF0;
  localparam logic [7:0] OP_LD_EXT  = 8'h4D;
  localparam logic [7:0] OP_LD_HI   = 8'h48;
  localparam logic [7:0] OP_LD_LO   = 8'h40;
  localparam logic [7:0] OP_RD_HI   = 8'h28;
  localparam logic [7:0] OP_RD_LO   = 8'h20;
  localparam logic [7:0] OP_RD_EE   = 8'hA0;
  localparam logic [7:0] OP_RD_LOCK = 8'h58;
  localparam logic [7:0] OP_RD_SIG  = 8'h30;
  localparam logic [7:0] OP_RD_FUSE = 8'h50;
  localparam logic [7:0] OP_RD_CAL  = 8'h38;
  localparam logic [7:0] OP_WR_PAGE = 8'h4C;
  localparam logic [7:0] OP_WR_EE   = 8'hC0;
  localparam logic [7:0] ERASED     = 8'hFF;
  localparam logic [7:0] FUSE_VAL   = 8'hFF;
  // Arbitrary neutral signature value
  localparam logic [7:0] SIG_VAL    = 8'h5A;
  localparam logic [2:0] BIT_LAST   = 3'h7;
  localparam logic [1:0] BYTE_3     = 2'h2;
  localparam logic [1:0] BYTE_4     = 2'h3;

  typedef enum logic [3:0] {
    EX_IDLE  = 4'b0001,
    EX_PAGE  = 4'b0010,
    EX_ERASE = 4'b0100,
    EX_WAIT  = 4'b1000
  } isp_ex_t;

endpackage

// *** rtl/isp_fifo_if.sv ***
`timescale 1ns/1ps
interface isp_fifo_if #(parameter int W = 32);
  logic         push_valid;
  logic         push_ready;
  logic [W-1:0] push_data;
  logic         pop_valid;
  logic         pop_ready;
  logic [W-1:0] pop_data;

  modport fifo (input push_valid, push_data, pop_ready,
                output push_ready, pop_valid, pop_data);
  modport user (output push_valid, push_data, pop_ready,
                input push_ready, pop_valid, pop_data);
endinterface

// *** rtl/isp_fifo.sv ***
`timescale 1ns/1ps
module isp_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Both sides
  isp_fifo_if.fifo ff
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } isp_ff_st_t;

  isp_ff_st_t   r;
  isp_ff_st_t   n;
  logic [W-1:0] mem [DEPTH];
  logic         full;
  logic         empty;
  logic         do_push;

  assign empty         = (r.wp == r.rp);
  assign full          = (r.wp[AW] != r.rp[AW]) && (r.wp[AW-1:0] == r.rp[AW-1:0]);
  assign ff.push_ready = ~full;
  assign ff.pop_valid  = ~empty;
  assign ff.pop_data   = mem[r.rp[AW-1:0]];
  assign do_push       = ff.push_valid & ~full;

  always_comb begin
    n = r;
    if (do_push) begin
      n.wp = r.wp + 1'b1;
    end
    if (ff.pop_ready && !empty) begin
      n.rp = r.rp + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[r.wp[AW-1:0]] <= ff.push_data;
    end
  end
endmodule // isp_fifo

// *** bench/isp_prog_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------
// Programmer on the far side of the link
// ------------------------------------------------
module isp_prog_model (
  // Clock
  input  wire logic clk,
  // Link
  output logic      prog_sck,
  output logic      prog_serial_in,
  input  wire logic prog_serial_out
);
  initial begin
    prog_sck       = 1'b0;
    prog_serial_in = 1'b0;
  end

  // Whole four-byte frame, clock parked low between frames
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    @(posedge clk);
    for (int i = 31; i >= 0; i--) begin
      prog_serial_in <= tx[i];
      repeat (4) @(posedge clk);
      prog_sck <= 1'b1;
      repeat (4) @(posedge clk);
      rx[i] = prog_serial_out;
      prog_sck <= 1'b0;
    end
    @(posedge clk);
    prog_serial_in <= ~tx[0];
  endtask
endmodule // isp_prog_model

// *** bench/isp_serial_port_checker.sv ***
`timescale 1ns/1ps
module isp_serial_port_checker #(
  parameter int PAGE_WAIT_CYCLES  = 20,
  parameter int EE_WAIT_CYCLES    = 20,
  parameter int ERASE_WAIT_CYCLES = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Pins
  input wire logic prog_reset_n,
  input wire logic prog_sck,
  input wire logic prog_serial_in,
  input wire logic prog_serial_out,
  // Status
  input wire logic prog_enabled,
  input wire logic write_pending_flag
);
  import isp_pkg::*;
  localparam int MIN_W = EE_WAIT_CYCLES < PAGE_WAIT_CYCLES ? EE_WAIT_CYCLES : PAGE_WAIT_CYCLES;
  logic        sck_r;
  logic [4:0]  rise_cnt_r;
  logic [3:0]  fall_age_r;
  logic [19:0] pend_len_r;
  logic [31:0] frame_r;
  logic        long_r;
  logic        sck_up;
  logic        long_end;

  // Long writes only; loads and reads pend for a few cycles
  assign sck_up   = !prog_reset_n && prog_sck && !sck_r;
  assign long_end = sck_up && prog_enabled && rise_cnt_r == 5'h1F &&
                    (frame_r[30:23] == OP_WR_EE || frame_r[30:23] == OP_WR_PAGE ||
                     frame_r[30:15] == {OP_ENABLE, SUB_ERASE});

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ------------------------------------------------
  // Edge and length trackers
  // ------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sck_r      <= 1'b0;
      rise_cnt_r <= 5'h0;
      fall_age_r <= 4'h0;
      pend_len_r <= 20'h0;
      frame_r    <= 32'h0;
      long_r     <= 1'b0;
    end else begin
      if (sck_up) begin
        frame_r <= {frame_r[30:0], prog_serial_in};
      end
      if (long_end) begin
        long_r <= 1'b1;
      end else if (pend_len_r != 20'h0 && !write_pending_flag) begin
        long_r <= 1'b0;
      end
      sck_r      <= prog_sck;
      rise_cnt_r <= prog_reset_n ? 5'h0 : rise_cnt_r + 5'(prog_sck & ~sck_r);
      fall_age_r <= (sck_r & ~prog_sck) ? 4'h0 : fall_age_r + 4'(fall_age_r != 4'hF);
      pend_len_r <= write_pending_flag ? pend_len_r + 20'h1 : 20'h0;
    end
  end

  property p_quiet_en;
    prog_reset_n [*5] |-> !prog_enabled;
  endproperty
  a_quiet_en: assert property (p_quiet_en) else $error("enable high with pin high");
  property p_quiet_out;
    prog_reset_n [*5] |-> !prog_serial_out;
  endproperty
  a_quiet_out: assert property (p_quiet_out) else $error("output busy with pin high");
  property p_out_on_fall;
    $changed(prog_serial_out) && !prog_reset_n |-> fall_age_r inside {[4'h1:4'h6]};
  endproperty
  a_out_on_fall: assert property (p_out_on_fall) else $error("output moved off fall");
  property p_en_on_frame;
    $rose(prog_enabled) |-> rise_cnt_r == 5'h0 && !prog_reset_n;
  endproperty
  a_en_on_frame: assert property (p_en_on_frame) else $error("enable off frame");
  property p_pend_on_frame;
    $rose(write_pending_flag) |-> rise_cnt_r == 5'h0;
  endproperty
  a_pend_on_frame: assert property (p_pend_on_frame) else $error("pending off frame");
  property p_pend_needs_en;
    $rose(write_pending_flag) |-> prog_enabled;
  endproperty
  a_pend_needs_en: assert property (p_pend_needs_en) else $error("work while locked");
  property p_pend_len;
    $fell(write_pending_flag) && long_r |-> pend_len_r >= 20'(MIN_W);
  endproperty
  a_pend_len: assert property (p_pend_len) else $error("pending too short");
  property p_en_holds;
    $fell(prog_enabled) |-> prog_reset_n && $past(prog_reset_n);
  endproperty
  a_en_holds: assert property (p_en_holds) else $error("enable lost");
endmodule // isp_serial_port_checker

// *** bench/isp_serial_port_tb_top.sv ***
`timescale 1ns/1ps
module isp_serial_port_tb_top;
  import isp_pkg::*;
  localparam int WC = 300;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        prog_reset_n = 1'b1;
  logic        prog_sck;
  logic        prog_serial_in;
  logic        prog_serial_out;
  logic        prog_enabled;
  logic        write_pending_flag;
  logic [31:0] rx;
  int          bad_count = 0;
  int          compares = 0;

  always #12.5 clk = ~clk;

  isp_serial_port #(.PAGE_WAIT_CYCLES(WC), .EE_WAIT_CYCLES(WC), .ERASE_WAIT_CYCLES(WC)) uut (
    .clk(clk), .sys_rst(sys_rst), .prog_reset_n(prog_reset_n), .prog_sck(prog_sck),
    .prog_serial_in(prog_serial_in), .prog_serial_out(prog_serial_out),
    .prog_enabled(prog_enabled), .write_pending_flag(write_pending_flag));
  isp_prog_model pm (.clk(clk), .prog_sck(prog_sck), .prog_serial_in(prog_serial_in),
    .prog_serial_out(prog_serial_out));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmd(input logic [31:0] tx);
    pm.xfer(tx, rx);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      cmd({OP_POLL, 24'h0});
      n++;
    end while (rx[0] !== 1'b0 && n < 40);
    chk("poll", 8'h00, rx[7:0]);
  endtask
  task automatic test_done;
    $display("Counts: %0d compares, %0d mismatches", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic t_refuse;
    cmd({OP_WR_EE, 24'h01235A});
    cmd({OP_RD_EE, 24'h012300});
    chk("rd_locked", 8'h00, rx[7:0]);
    chk("pend_locked", 8'h00, {7'h0, write_pending_flag});
    $display("t_refuse done");
  endtask
  task automatic t_enable;
    cmd({OP_ENABLE, SUB_ENABLE, 16'h0});
    chk("echo", SUB_ENABLE, rx[15:8]);
    chk("echo_b1", OP_ENABLE, rx[23:16]);
    repeat (8) @(posedge clk);
    chk("enabled", 8'h01, {7'h0, prog_enabled});
    $display("t_enable done");
  endtask
  task automatic t_ident;
    cmd({OP_RD_SIG, 24'h000000});
    chk("sig", SIG_VAL, rx[7:0]);
    cmd({OP_RD_FUSE, 24'h000000});
    chk("fuse", FUSE_VAL, rx[7:0]);
    cmd({OP_RD_LOCK, 24'h000000});
    chk("lock", FUSE_VAL, rx[7:0]);
    cmd({OP_RD_CAL, 24'h000000});
    chk("cal", FUSE_VAL, rx[7:0]);
    $display("t_ident done");
  endtask
  task automatic t_erase;
    cmd({OP_ENABLE, SUB_ERASE, 16'h0});
    cmd({OP_POLL, 24'h0});
    chk("busy", 8'h01, rx[7:0]);
    wait_idle();
    cmd({OP_RD_EE, 24'h0ABC00});
    chk("ee_erased", ERASED, rx[7:0]);
    cmd({OP_LD_EXT, 24'h000000});
    cmd({OP_RD_HI, 24'h03FF00});
    chk("fl_erased", ERASED, rx[7:0]);
    $display("t_erase done");
  endtask
  task automatic t_eeprom;
    cmd({OP_WR_EE, 24'h0123C3});
    repeat (4) @(posedge clk);
    chk("pend", 8'h01, {7'h0, write_pending_flag});
    wait_idle();
    cmd({OP_WR_EE, 24'h01233C});
    wait_idle();
    cmd({OP_RD_EE, 24'h012300});
    chk("ee_rd", 8'h3C, rx[7:0]);
    $display("t_eeprom done");
  endtask
  task automatic t_flash;
    cmd({OP_LD_LO, 24'h000511});
    cmd({OP_LD_HI, 24'h000522});
    cmd({OP_WR_PAGE, 24'h010000});
    wait_idle();
    cmd({OP_RD_LO, 24'h010500});
    chk("fl_lo", 8'h11, rx[7:0]);
    cmd({OP_RD_HI, 24'h010500});
    chk("fl_hi", 8'h22, rx[7:0]);
    $display("t_flash done");
  endtask
  task automatic t_exit;
    prog_reset_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk("en_off", 8'h00, {7'h0, prog_enabled});
    prog_reset_n <= 1'b0;
    repeat (8) @(posedge clk);
    cmd({OP_RD_EE, 24'h012300});
    chk("rd_relocked", 8'h00, rx[7:0]);
    cmd({OP_ENABLE, SUB_ENABLE, 16'h0});
    cmd({OP_RD_EE, 24'h012300});
    chk("ee_kept", 8'h3C, rx[7:0]);
    $display("t_exit done");
  endtask

  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    prog_reset_n <= 1'b0;
    repeat (8) @(posedge clk);
    t_refuse();
    t_enable();
    t_ident();
    t_erase();
    t_eeprom();
    t_flash();
    t_exit();
    test_done();
  end

  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    $display("Error watchdog expected done seen hang");
    test_done();
  end
endmodule // isp_serial_port_tb_top

bind isp_serial_port isp_serial_port_checker #(.PAGE_WAIT_CYCLES(PAGE_WAIT_CYCLES),
  .EE_WAIT_CYCLES(EE_WAIT_CYCLES), .ERASE_WAIT_CYCLES(ERASE_WAIT_CYCLES)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .prog_reset_n(prog_reset_n), .prog_sck(prog_sck),
  .prog_serial_in(prog_serial_in), .prog_serial_out(prog_serial_out),
  .prog_enabled(prog_enabled), .write_pending_flag(write_pending_flag));
